// ---- bus_signal_defs.svh ----
`ifndef BUS_SIGNAL_DEFS_SVH
`define BUS_SIGNAL_DEFS_SVH

`define WORD_ADDR_LSB 2
`define PAGE_ADDR_LSB 11
`define BURST_WORDS 4
`define FIFO_DEPTH 16
`define ADDR_W 32
`define DATA_W 32

`endif

// ---- bus_signal_pkg.sv ----
package bus_signal_pkg;

    // Processor request delivered through the request FIFO.
    typedef struct packed {
        logic        write;
        logic        miss;
        logic        instr;
        logic        quad_refill;
        logic        cached_store;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bus_req_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_RDATA,
        ST_WDATA,
        ST_DMA
    } bus_state_t;

endpackage

// ---- req_fifo.sv ----
`timescale 1ns/1ps
module req_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } fifo_state_t;

    logic [WIDTH-1:0] mem [DEPTH];
    fifo_state_t st_q;
    fifo_state_t st_d;
    logic push;
    logic pop;

    // Ready drops only when every slot holds a word.
    assign o_in_ready = (st_q.count != (AW+1)'(DEPTH));
    assign o_out_valid = (st_q.count != '0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem[st_q.rd];

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.wr = st_q.wr + AW'(1);
        end
        if (pop) begin
            st_d.rd = st_q.rd + AW'(1);
        end
        if (push && !pop) begin
            st_d.count = st_q.count + (AW+1)'(1);
        end else if (pop && !push) begin
            st_d.count = st_q.count - (AW+1)'(1);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
        if (push) begin
            mem[st_q.wr] <= i_in_data;
        end
    end
endmodule

// ---- bus_signal.sv ----
`timescale 1ns/1ps
`include "bus_signal_defs.svh"
module bus_signal
    import bus_signal_pkg::*;
#(
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire bus_req_t i_req,
    output logic o_rdata_valid,
    output logic [`DATA_W-1:0] o_rdata,
    input wire logic [`DATA_W-1:0] i_ad,
    output logic [`DATA_W-1:0] o_ad,
    output logic o_ad_oe,
    input wire logic i_ale,
    output logic o_ale,
    output logic o_ale_oe,
    output logic o_rd,
    input wire logic i_wr,
    output logic o_wr,
    output logic o_wr_oe,
    output logic [1:0] o_word_index,
    output logic o_diag_hi,
    output logic o_diag_lo,
    output logic o_external_drive_permit,
    output logic o_burst_or_near_write,
    input wire logic i_ack,
    input wire logic i_coherent_dma,
    output logic o_dma_addr_valid,
    output logic [`ADDR_W-1:0] o_dma_addr
);
    localparam int REQ_W = $bits(bus_req_t);

    // ========================================================================
    // State record.
    // ========================================================================
    // Every bus-facing output comes from this record, straight from a field or, for the two pin enables, decoded from the state field, so
    // that no output ever glitches on a combinational path from the inputs.
    typedef struct packed {
        bus_state_t state;
        bus_req_t req;
        logic [1:0] beat;
        logic burst;
        logic last_was_write;
        logic [`ADDR_W-1:`PAGE_ADDR_LSB] last_page;
        logic [`DATA_W-1:0] ad;
        logic ad_oe;
        logic ale;
        logic rd;
        logic wr;
        logic permit;
        logic diag_hi;
        logic diag_lo;
        logic bnw;
        logic [1:0] widx;
        logic rvalid;
        logic [`DATA_W-1:0] rdata;
        logic ale_prev;
        logic dvalid;
        logic [`ADDR_W-1:0] daddr;
    } core_state_t;

    core_state_t s_q;
    core_state_t s_d;
    logic f_valid;
    logic f_ready;
    logic [REQ_W-1:0] f_data;
    bus_req_t f_req;

    // ========================================================================
    // Request queue.
    // ========================================================================
    // The queue decouples the request side from bus wait states and from the
    // time the bus is lent to a DMA master.
    assign f_req = bus_req_t'(f_data);

    req_fifo #(
        .WIDTH(REQ_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_in_valid(i_req_valid),
        .o_in_ready(o_req_ready),
        .i_in_data(i_req),
        .o_out_valid(f_valid),
        .i_out_ready(f_ready),
        .o_out_data(f_data)
    );

    // A new request is drawn only when the bus is idle and not lent to DMA.
    assign f_ready = (s_q.state == ST_IDLE) && !i_coherent_dma;

    // ========================================================================
    // Decoding helpers.
    // ========================================================================
    // Only miss reads may ask for a block, and data misses only when the
    // quad-word refill is selected.
    function automatic logic wants_burst(input bus_req_t r);
        wants_burst = !r.write && r.miss && (r.instr || r.quad_refill);
    endfunction

    // The address phase carries the high address bits with all byte lanes on.
    function automatic logic [`DATA_W-1:0] addr_phase_word(input logic [`ADDR_W-1:0] a);
        addr_phase_word = {a[`ADDR_W-1:4], 4'hF};
    endfunction

    // A burst starts its word index at zero; a single transfer shows its word.
    function automatic logic [1:0] first_index(input bus_req_t r);
        if (wants_burst(r)) begin
            first_index = 2'h0;
        end else begin
            first_index = r.addr[`WORD_ADDR_LSB+1:`WORD_ADDR_LSB];
        end
    endfunction

    // Two addresses share a page when all bits above the page offset agree.
    function automatic logic same_page(
        input logic [`ADDR_W-1:`PAGE_ADDR_LSB] prev,
        input logic [`ADDR_W-1:0] a
    );
        same_page = (prev == a[`ADDR_W-1:`PAGE_ADDR_LSB]);
    endfunction

    // ========================================================================
    // Next state.
    // ========================================================================

    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.dvalid = 1'b0;
        s_d.ale_prev = i_ale;
        unique case (s_q.state)
            ST_IDLE: begin
                s_d.permit = 1'b0;
                s_d.rd = 1'b0;
                s_d.wr = 1'b0;
                s_d.ad_oe = 1'b0;
                s_d.bnw = 1'b0;
                if (i_coherent_dma) begin
                    s_d.state = ST_DMA;
                end else if (f_valid) begin
                    s_d.state = ST_ADDR;
                    s_d.req = f_req;
                    s_d.beat = 2'h0;
                    s_d.burst = wants_burst(f_req);
                    s_d.ad = addr_phase_word(f_req.addr);
                    s_d.ad_oe = 1'b1;
                    s_d.ale = 1'b1;
                    s_d.rd = !f_req.write;
                    s_d.wr = f_req.write;
                    s_d.widx = first_index(f_req);
                    if (f_req.write) begin
                        s_d.diag_hi = f_req.cached_store;
                        s_d.diag_lo = 1'b0;
                        s_d.bnw = s_q.last_was_write &&
                            same_page(s_q.last_page, f_req.addr);
                    end else begin
                        s_d.diag_hi = f_req.miss;
                        s_d.diag_lo = f_req.miss ? f_req.instr : 1'b0;
                        s_d.bnw = wants_burst(f_req);
                    end
                end
            end
            ST_ADDR: begin
                s_d.ale = 1'b0;
                if (s_q.req.write) begin
                    s_d.state = ST_WDATA;
                    s_d.ad = s_q.req.wdata;
                    s_d.diag_hi = 1'b0;
                end else begin
                    s_d.state = ST_RDATA;
                    s_d.ad_oe = 1'b0;
                    s_d.diag_lo = s_q.req.addr[`WORD_ADDR_LSB];
                end
            end
            ST_RDATA: begin
                // The permit rises one cycle after the bus driver turned off.
                s_d.permit = 1'b1;
                if (i_ack && s_q.permit) begin
                    s_d.rvalid = 1'b1;
                    s_d.rdata = i_ad;
                    if (s_q.burst && s_q.beat != 2'(`BURST_WORDS - 1)) begin
                        s_d.beat = s_q.beat + 2'h1;
                        s_d.widx = s_q.widx + 2'h1;
                    end else begin
                        s_d.state = ST_IDLE;
                        s_d.permit = 1'b0;
                        s_d.rd = 1'b0;
                        s_d.bnw = 1'b0;
                        s_d.last_was_write = 1'b0;
                    end
                end
            end
            ST_WDATA: begin
                s_d.permit = 1'b0;
                if (i_ack) begin
                    s_d.state = ST_IDLE;
                    s_d.wr = 1'b0;
                    s_d.ad_oe = 1'b0;
                    s_d.bnw = 1'b0;
                    s_d.last_was_write = 1'b1;
                    s_d.last_page = s_q.req.addr[`ADDR_W-1:`PAGE_ADDR_LSB];
                end
            end
            ST_DMA: begin
                s_d.permit = 1'b0;
                s_d.ad_oe = 1'b0;
                s_d.ale = 1'b0;
                s_d.rd = 1'b0;
                s_d.wr = 1'b0;
                s_d.last_was_write = 1'b0;
                // Rising latch strobe with a master write captures the target.
                if (i_ale && !s_q.ale_prev && i_wr) begin
                    s_d.dvalid = 1'b1;
                    s_d.daddr = {i_ad[`ADDR_W-1:4], o_word_index, 2'h0};
                end
                if (!i_coherent_dma) begin
                    s_d.state = ST_IDLE;
                end
            end
            default: begin
                s_d.state = ST_IDLE;
            end
        endcase
    end

    // ========================================================================
    // State register.
    // ========================================================================
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================================================
    // Outputs.
    // ========================================================================
    // The latch strobe and write pins are released while the bus is lent out.
    assign o_ad = s_q.ad;
    assign o_ad_oe = s_q.ad_oe;
    assign o_ale = s_q.ale;
    assign o_ale_oe = (s_q.state != ST_DMA);
    assign o_rd = s_q.rd;
    assign o_wr = s_q.wr;
    assign o_wr_oe = (s_q.state != ST_DMA);
    assign o_word_index = s_q.widx;
    assign o_diag_hi = s_q.diag_hi;
    assign o_diag_lo = s_q.diag_lo;
    assign o_external_drive_permit = s_q.permit;
    assign o_burst_or_near_write = s_q.bnw;
    assign o_rdata_valid = s_q.rvalid;
    assign o_rdata = s_q.rdata;
    assign o_dma_addr_valid = s_q.dvalid;
    assign o_dma_addr = s_q.daddr;
endmodule

// ---- bus_signal_properties.sv ----
`timescale 1ns/1ps
module bus_signal_properties (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_ale,
    input wire logic i_wr,
    input wire logic i_ack,
    input wire logic i_coherent_dma,
    input wire logic o_ale,
    input wire logic o_rd,
    input wire logic o_wr,
    input wire logic o_ad_oe,
    input wire logic o_external_drive_permit,
    input wire logic o_burst_or_near_write,
    input wire logic o_diag_hi,
    input wire logic o_diag_lo,
    input wire logic [1:0] o_word_index,
    input wire logic o_rdata_valid,
    input wire logic o_dma_addr_valid
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    sequence s_addr_rd;
        o_ale && o_rd;
    endsequence
    sequence s_take_word;
        o_external_drive_permit && i_ack;
    endsequence
    a_ale_single: assert property (o_ale |=> !o_ale) else $error("ale held");
    a_rd_wr_excl: assert property (!(o_rd && o_wr)) else $error("rd and wr");
    a_permit_idle: assert property (!o_rd |-> !o_external_drive_permit)
        else $error("permit off read");
    a_permit_release: assert property (o_external_drive_permit |-> !o_ad_oe)
        else $error("permit while driving");
    a_permit_late: assert property (s_addr_rd |=> !o_external_drive_permit)
        else $error("permit early");
    a_burst_miss: assert property (s_addr_rd and !o_diag_hi |-> !o_burst_or_near_write)
        else $error("burst without miss");
    a_word_taken: assert property (s_take_word |=> o_rdata_valid) else $error("word lost");
    a_lo_bit: assert property (o_rd && !o_ale && !o_burst_or_near_write |->
        o_diag_lo == o_word_index[0]) else $error("diag lo bit");
    a_dma_capture: assert property ($rose(i_ale) && i_wr && i_coherent_dma |=>
        o_dma_addr_valid) else $error("dma addr missed");
endmodule
bind bus_signal bus_signal_properties u_props (.i_ref_clk, .i_reset, .i_ale, .i_wr, .i_ack,
    .i_coherent_dma, .o_ale, .o_rd, .o_wr, .o_ad_oe, .o_external_drive_permit,
    .o_burst_or_near_write, .o_diag_hi, .o_diag_lo, .o_word_index, .o_rdata_valid,
    .o_dma_addr_valid);

// ---- mem_partner.sv ----
`timescale 1ns/1ps
module mem_partner (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_permit,
    input wire logic i_wr,
    input wire logic i_ale,
    input wire logic [1:0] i_idx,
    input wire logic i_slow,
    output logic o_ack,
    output logic [31:0] o_ad
);
    logic [1:0] wait_q;
    // Data only while permitted; otherwise a changing pattern, not the last word.
    assign o_ad = i_permit ? 32'hC0DE0000 + i_idx : ~(32'hC0DE0000 + i_idx);
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_ack <= 1'b0;
            wait_q <= 2'h0;
        end else if ((i_permit || (i_wr && !i_ale)) && !o_ack) begin
            if (wait_q == (i_slow ? 2'h3 : 2'h0)) begin
                o_ack <= 1'b1;
                wait_q <= 2'h0;
            end else begin
                wait_q <= wait_q + 2'h1;
            end
        end else begin
            o_ack <= 1'b0;
        end
    end
endmodule

// ---- bus_signal_tb.sv ----
`timescale 1ns/1ps
module bus_signal_tb;
    import bus_signal_pkg::*;
    logic i_ref_clk = 0, i_reset = 1, i_req_valid = 0, tb_ale = 0, tb_wr = 0;
    logic i_coherent_dma = 0, slow = 0;
    bus_req_t i_req = '0;
    logic [31:0] dma_ad = '0, mem_ad, o_rdata, o_ad, o_dma_addr;
    logic o_req_ready, o_rdata_valid, o_ad_oe, o_ale, o_ale_oe, o_rd, o_wr, o_wr_oe, i_ack;
    logic o_diag_hi, o_diag_lo, o_external_drive_permit, o_burst_or_near_write;
    logic o_dma_addr_valid;
    logic [1:0] o_word_index;
    int miscompares = 0, checks_done = 0, cyc = 0;
    wire [31:0] i_ad = i_coherent_dma ? dma_ad : mem_ad;
    wire i_ale = o_ale_oe ? o_ale : tb_ale;
    wire i_wr = o_wr_oe ? o_wr : tb_wr;
    always #12.5 i_ref_clk = ~i_ref_clk;
    bus_signal dut (.i_ref_clk, .i_reset, .i_req_valid, .o_req_ready, .i_req, .o_rdata_valid,
        .o_rdata, .i_ad, .o_ad, .o_ad_oe, .i_ale, .o_ale, .o_ale_oe, .o_rd, .i_wr, .o_wr,
        .o_wr_oe, .o_word_index, .o_diag_hi, .o_diag_lo, .o_external_drive_permit,
        .o_burst_or_near_write, .i_ack, .i_coherent_dma, .o_dma_addr_valid, .o_dma_addr);
    mem_partner mem (.i_ref_clk, .i_reset, .i_permit(o_external_drive_permit), .i_wr(o_wr),
        .i_ale(o_ale), .i_idx(o_word_index), .i_slow(slow), .o_ack(i_ack), .o_ad(mem_ad));
    task results;
        if (miscompares == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task push(input bus_req_t r);
        @(posedge i_ref_clk);
        i_req <= r;
        i_req_valid <= 1;
        do @(negedge i_ref_clk); while (!o_req_ready);
        @(posedge i_ref_clk);
        i_req_valid <= 0;
    endtask
    task t_read(input logic miss, instr, quad, input logic [31:0] a);
        logic bst;
        bst = miss && (instr || quad);
        push('{1'b0, miss, instr, quad, 1'b0, a, 32'h0});
        @(negedge i_ref_clk iff o_ale);
        chk(o_rd, 1);
        chk(o_diag_hi, miss);
        if (miss) chk(o_diag_lo, instr);
        chk(o_burst_or_near_write, bst);
        chk(o_ad, {a[31:4], 4'hF});
        @(negedge i_ref_clk);
        chk(o_diag_lo, a[2]);
        chk(o_ad_oe, 0);
        for (int n = 0; n < (bst ? 4 : 1); n++) begin
            @(negedge i_ref_clk iff o_rdata_valid);
            chk(o_rdata, 32'hC0DE0000 + (bst ? n : a[3:2]));
        end
    endtask
    task t_write(input logic cached, input logic [31:0] a, input logic near);
        push('{1'b1, 1'b0, 1'b0, 1'b0, cached, a, 32'hA5A50000});
        @(negedge i_ref_clk iff o_ale);
        chk(o_wr, 1);
        chk(o_diag_hi, cached);
        chk(o_burst_or_near_write, near);
        chk(o_ad, {a[31:4], 4'hF});
        @(negedge i_ref_clk);
        chk(o_ad, 32'hA5A50000);
        chk(o_external_drive_permit, 0);
        @(negedge i_ref_clk iff !o_wr);
    endtask
    task t_fill_dma;
        int k;
        @(posedge i_ref_clk);
        i_coherent_dma <= 1;
        i_req <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h6000, 32'h0};
        i_req_valid <= 1;
        k = 0;
        repeat (20) begin
            @(negedge i_ref_clk);
            k += o_req_ready;
            @(posedge i_ref_clk);
        end
        i_req_valid <= 0;
        tb_ale <= 1;
        tb_wr <= 1;
        dma_ad <= 32'h1234567C;
        chk(k, 16);
        @(posedge i_ref_clk);
        tb_ale <= 0;
        @(negedge i_ref_clk iff o_dma_addr_valid);
        chk({o_dma_addr[31:4], o_dma_addr[1:0]}, {28'h1234567, 2'b00});
        @(posedge i_ref_clk);
        tb_wr <= 0;
        i_coherent_dma <= 0;
        repeat (16) @(negedge i_ref_clk iff o_ale);
        @(negedge i_ref_clk iff !o_wr);
        chk(o_req_ready, 1);
    endtask
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            results;
        end
    end
    initial begin
        repeat (5) @(posedge i_ref_clk);
        i_reset <= 0;
        t_read(1, 1, 0, 32'h100C);
        slow <= 1;
        t_read(1, 0, 0, 32'h2008);
        t_read(1, 0, 1, 32'h3000);
        t_read(0, 0, 0, 32'h4004);
        t_write(1, 32'h5000, 0);
        t_write(0, 32'h57FC, 1);
        t_write(0, 32'h5800, 0);
        t_fill_dma;
        results;
    end
endmodule
